// *** verilog/dct_channel.sv ***
// Channel logic: AHB-Lite registers, trigger select, counters, destination.
`timescale 1ns/10ps
module dct_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] ev_req,
  input wire logic crypto_req,
  input wire logic [4:0] adc0_req,
  input wire logic [1:0] dac0_req,
  input wire logic [4:0] adc1_req,
  input wire logic [1:0] dac1_req,
  input wire logic [3:0][5:0] port_timer0_req,
  input wire logic [3:0][3:0] port_timer1_req,
  input wire logic [3:0] port_spi_req,
  input wire logic [3:0][1:0] port_ser0_req,
  input wire logic [3:0][1:0] port_ser1_req,
  input wire logic byte_read,
  input wire logic byte_written,
  input wire logic burst_done,
  input wire logic xfer_error,
  output logic xfer_req,
  output logic channel_busy_flag,
  output logic [23:0] dest_addr,
  output logic [15:0] block_byte_count,
  output logic [1:0] dest_step_mode
);
  dct_pkg::dct_regs_t r_reg;
  dct_pkg::dct_regs_t r_next;
  logic [2:0] ev_s1_reg;
  logic [2:0] ev_s2_reg;
  logic [95:0] per_s1_reg;
  logic [95:0] per_s2_reg;
  logic [95:0] per_raw;
  logic [255:0] trig_vec;
  logic hw_trig;
  logic block_end;
  logic last_block;
  logic [7:0] widx;
  logic [7:0] wb;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger lines come from other logic and pass two flops before use.

  assign per_raw = {crypto_req, adc0_req, dac0_req, adc1_req, dac1_req,
                    port_timer0_req, port_timer1_req, port_spi_req,
                    port_ser0_req, port_ser1_req, 21'h0};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_s1_reg <= 3'h0;
      ev_s2_reg <= 3'h0;
      per_s1_reg <= 96'h0;
      per_s2_reg <= 96'h0;
    end else begin
      ev_s1_reg <= ev_req;
      ev_s2_reg <= ev_s1_reg;
      per_s1_reg <= per_raw;
      per_s2_reg <= per_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code space: unused codes stay zero and so never fire.

  always_comb begin
    logic [7:0] b;
    b = 8'h00;
    trig_vec = 256'h0;
    for (int e = 0; e < 3; e++) begin
      trig_vec[8'(dct_pkg::DCT_TRG_EVSYS + 8'(e))] = ev_s2_reg[e];
    end
    trig_vec[dct_pkg::DCT_TRG_CRYPTO] = per_s2_reg[95];
    for (int c = 0; c < 5; c++) begin
      trig_vec[8'(dct_pkg::DCT_TRG_ADC0 + 8'(c))] = per_s2_reg[90 + c];
      trig_vec[8'(dct_pkg::DCT_TRG_ADC1 + 8'(c))] = per_s2_reg[83 + c];
    end
    for (int c = 0; c < 2; c++) begin
      trig_vec[8'(dct_pkg::DCT_TRG_DAC0 + 8'(c))] = per_s2_reg[88 + c];
      trig_vec[8'(dct_pkg::DCT_TRG_DAC1 + 8'(c))] = per_s2_reg[81 + c];
    end
    for (int p = 0; p < 4; p++) begin
      b = 8'(dct_pkg::DCT_TRG_PORT0 + 8'(p) * dct_pkg::DCT_PORT_STRIDE);
      for (int t = 0; t < 6; t++) begin
        trig_vec[8'(b + 8'(t))] = per_s2_reg[57 + p * 6 + t];
      end
      for (int t = 0; t < 4; t++) begin
        trig_vec[8'(b + 8'(dct_pkg::DCT_OFS_TMR1) + 8'(t))] =
          per_s2_reg[41 + p * 4 + t];
      end
      trig_vec[8'(b + 8'(dct_pkg::DCT_OFS_SPI))] = per_s2_reg[37 + p];
      for (int s = 0; s < 2; s++) begin
        trig_vec[8'(b + 8'(dct_pkg::DCT_OFS_SER0) + 8'(s))] =
          per_s2_reg[29 + p * 2 + s];
        trig_vec[8'(b + 8'(dct_pkg::DCT_OFS_SER1) + 8'(s))] =
          per_s2_reg[21 + p * 2 + s];
      end
    end
    trig_vec[8'h00] = 1'b0;
  end

  // A request line low means the peripheral cleared its flag, so the
  // pending request simply falls away; nothing is latched here.
  assign hw_trig = trig_vec[r_reg.trig];

  assign block_end = (r_reg.st == dct_pkg::DCT_RUN) && byte_read &&
                     (r_reg.cnt == 16'h0001);
  assign last_block = r_reg.repeat_en && (r_reg.rep == 8'h01);
  assign widx = r_reg.dph.idx;
  assign wb = hwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic done_set;
    logic err_set;
    done_set = 1'b0;
    err_set = 1'b0;
    r_next = r_reg;
    r_next.req_taken = 1'b0;
    r_next.byte_ack = 1'b0;
    r_next.dph.sel = hsel && hready && htrans[1];
    if (hsel && hready) begin
      r_next.dph.write = hwrite;
      r_next.dph.idx = 8'(haddr[9:2]);
    end
    // Datapath: bytes stepping the count and the destination.
    if (r_reg.st == dct_pkg::DCT_RUN && byte_read) begin
      r_next.cnt = r_reg.cnt - 16'h0001;
    end
    if (r_reg.st == dct_pkg::DCT_RUN && byte_written) begin
      if (r_reg.actl.dir == dct_pkg::DCT_DIR_INC) begin
        r_next.dest = r_reg.dest + 24'h000001;
      end else if (r_reg.actl.dir == dct_pkg::DCT_DIR_DEC) begin
        r_next.dest = r_reg.dest - 24'h000001;
      end
    end
    if (burst_done && r_reg.actl.reload == dct_pkg::DCT_RL_BURST) begin
      r_next.dest = r_reg.dest_init;
    end
    case (r_reg.st)
      dct_pkg::DCT_IDLE: begin
        if (r_reg.enable) begin
          r_next.busy = 1'b1;
          r_next.st = dct_pkg::DCT_WAIT;
        end
      end
      dct_pkg::DCT_WAIT: begin
        if (r_reg.sw_req || hw_trig) begin
          r_next.sw_req = 1'b0;
          r_next.req_taken = 1'b1;
          r_next.st = dct_pkg::DCT_RUN;
          if (r_reg.cnt == 16'h0000) begin
            r_next.cnt = dct_pkg::DCT_CNT_ZERO_RUN;
          end
          if (last_block) begin
            r_next.repeat_en = 1'b0;
          end
        end
      end
      dct_pkg::DCT_RUN: begin
        if (block_end) begin
          r_next.cnt = r_reg.cnt_init;
          if (r_reg.actl.reload == dct_pkg::DCT_RL_BLOCK) begin
            r_next.dest = r_reg.dest_init;
          end
          // The last block has already lost its repeat bit, so the
          // count must not be gated by that bit or it stops at one.
          if (r_reg.rep != 8'h00) begin
            r_next.rep = r_reg.rep - 8'h01;
          end
          if (r_reg.repeat_en && r_reg.rep != 8'h01) begin
            r_next.st = dct_pkg::DCT_WAIT;
            if (r_reg.rep == 8'h00) begin
              r_next.done = 1'b1;
              done_set = 1'b1;
            end
          end else begin
            r_next.done = 1'b1;
            done_set = 1'b1;
            r_next.busy = 1'b0;
            r_next.enable = 1'b0;
            r_next.st = dct_pkg::DCT_IDLE;
            if (r_reg.actl.reload == dct_pkg::DCT_RL_TRANS) begin
              r_next.dest = r_reg.dest_init;
            end
          end
        end
      end
      default: begin
        r_next.st = dct_pkg::DCT_IDLE;
      end
    endcase
    if (xfer_error && r_reg.busy) begin
      r_next.err = 1'b1;
      err_set = 1'b1;
      r_next.busy = 1'b0;
      r_next.enable = 1'b0;
      r_next.st = dct_pkg::DCT_IDLE;
    end
    // Register writes; flags set by hardware win over a software clear.
    if (r_reg.dph.sel && r_reg.dph.write) begin
      case (widx)
        dct_pkg::DCT_IDX_CTRL: begin
          r_next.enable = wb[dct_pkg::DCT_CTRL_EN];
          r_next.repeat_en = wb[dct_pkg::DCT_CTRL_REPEAT];
          r_next.sw_req = wb[dct_pkg::DCT_CTRL_SWREQ] && wb[0];
          if (!wb[dct_pkg::DCT_CTRL_EN]) begin
            r_next.busy = 1'b0;
            r_next.st = dct_pkg::DCT_IDLE;
          end
        end
        dct_pkg::DCT_IDX_ADDRCTRL: begin
          if (!r_reg.busy) begin
            r_next.actl = wb[3:0];
          end
        end
        dct_pkg::DCT_IDX_TRIG: begin
          r_next.trig = wb;
        end
        dct_pkg::DCT_IDX_CNTL: begin
          r_next.cnt[7:0] = wb;
          r_next.cnt_init[7:0] = wb;
        end
        dct_pkg::DCT_IDX_CNTH: begin
          r_next.cnt[15:8] = wb;
          r_next.cnt_init[15:8] = wb;
        end
        dct_pkg::DCT_IDX_REP: begin
          r_next.rep = wb;
        end
        dct_pkg::DCT_IDX_DEST: begin
          r_next.dest = hwdata[23:0];
          r_next.dest_init = hwdata[23:0];
        end
        dct_pkg::DCT_IDX_STATUS: begin
          if (wb[dct_pkg::DCT_ST_DONE] && !done_set) begin
            r_next.done = 1'b0;
          end
          if (wb[dct_pkg::DCT_ST_ERR] && !err_set) begin
            r_next.err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Read data is prepared for the cycle after the address phase.
    r_next.rdata = 32'h0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (8'(haddr[9:2]))
        dct_pkg::DCT_IDX_CTRL: begin
          r_next.rdata[2:0] = {r_reg.sw_req, r_reg.repeat_en, r_reg.enable};
        end
        dct_pkg::DCT_IDX_ADDRCTRL: begin
          r_next.rdata[3:0] = r_reg.actl;
        end
        dct_pkg::DCT_IDX_TRIG: begin
          r_next.rdata[7:0] = r_reg.trig;
        end
        dct_pkg::DCT_IDX_CNTL: begin
          r_next.rdata[7:0] = r_reg.cnt[7:0];
        end
        dct_pkg::DCT_IDX_CNTH: begin
          r_next.rdata[7:0] = r_reg.cnt[15:8];
        end
        dct_pkg::DCT_IDX_REP: begin
          r_next.rdata[7:0] = r_reg.rep;
        end
        dct_pkg::DCT_IDX_DEST: begin
          r_next.rdata[23:0] = r_reg.dest;
        end
        dct_pkg::DCT_IDX_STATUS: begin
          r_next.rdata[2:0] = {r_reg.err, r_reg.done, r_reg.busy};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.st <= dct_pkg::DCT_IDLE;
      r_reg.cnt <= dct_pkg::DCT_CNT_RESET;
      r_reg.cnt_init <= dct_pkg::DCT_CNT_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all but the constant hreadyout and hresp taken from the state register.

  assign hrdata = r_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign xfer_req = r_reg.req_taken;
  assign channel_busy_flag = r_reg.busy;
  assign dest_addr = r_reg.dest;
  assign block_byte_count = r_reg.cnt;
  assign dest_step_mode = r_reg.actl.dir;
endmodule // dct_channel

// *** verilog/dct_pkg.sv ***
// Package with register map, field layouts and trigger codes of the channel.
package dct_pkg;
  localparam logic [7:0] DCT_IDX_CTRL = 8'h00;
  localparam logic [7:0] DCT_IDX_ADDRCTRL = 8'h02;
  localparam logic [7:0] DCT_IDX_TRIG = 8'h03;
  localparam logic [7:0] DCT_IDX_CNTL = 8'h04;
  localparam logic [7:0] DCT_IDX_CNTH = 8'h05;
  localparam logic [7:0] DCT_IDX_REP = 8'h06;
  localparam logic [7:0] DCT_IDX_DEST = 8'h0c;
  localparam logic [7:0] DCT_IDX_STATUS = 8'h10;
  localparam int DCT_CTRL_EN = 0;
  localparam int DCT_CTRL_REPEAT = 1;
  localparam int DCT_CTRL_SWREQ = 2;
  localparam int DCT_ST_BUSY = 0;
  localparam int DCT_ST_DONE = 1;
  localparam int DCT_ST_ERR = 2;
  localparam logic [15:0] DCT_CNT_RESET = 16'h0001;
  localparam logic [15:0] DCT_CNT_ZERO_RUN = 16'hffff;
  localparam logic [1:0] DCT_RL_NONE = 2'h0;
  localparam logic [1:0] DCT_RL_BLOCK = 2'h1;
  localparam logic [1:0] DCT_RL_BURST = 2'h2;
  localparam logic [1:0] DCT_RL_TRANS = 2'h3;
  localparam logic [1:0] DCT_DIR_INC = 2'h1;
  localparam logic [1:0] DCT_DIR_DEC = 2'h2;
  localparam logic [7:0] DCT_TRG_EVSYS = 8'h01;
  localparam logic [7:0] DCT_TRG_CRYPTO = 8'h04;
  localparam logic [7:0] DCT_TRG_ADC0 = 8'h10;
  localparam logic [7:0] DCT_TRG_DAC0 = 8'h15;
  localparam logic [7:0] DCT_TRG_ADC1 = 8'h20;
  localparam logic [7:0] DCT_TRG_DAC1 = 8'h25;
  localparam logic [7:0] DCT_TRG_PORT0 = 8'h40;
  localparam logic [7:0] DCT_PORT_STRIDE = 8'h20;
  localparam logic [4:0] DCT_OFS_TMR1 = 5'h06;
  localparam logic [4:0] DCT_OFS_SPI = 5'h0a;
  localparam logic [4:0] DCT_OFS_SER0 = 5'h0b;
  localparam logic [4:0] DCT_OFS_SER1 = 5'h0e;

  typedef enum logic [2:0] {
    DCT_IDLE = 3'b001,
    DCT_WAIT = 3'b010,
    DCT_RUN = 3'b100
  } dct_state_t;

  typedef struct packed {
    logic [1:0] reload;
    logic [1:0] dir;
  } dct_addrctrl_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] idx;
  } dct_bus_t;

  typedef struct packed {
    dct_state_t st;
    dct_bus_t dph;
    logic enable;
    logic repeat_en;
    logic sw_req;
    logic busy;
    logic done;
    logic err;
    dct_addrctrl_t actl;
    logic [7:0] trig;
    logic [15:0] cnt_init;
    logic [15:0] cnt;
    logic [7:0] rep;
    logic [23:0] dest_init;
    logic [23:0] dest;
    logic [31:0] rdata;
    logic req_taken;
    logic byte_ack;
  } dct_regs_t;
endpackage

// *** verif/dct_checker.sv ***
// Checker with the concurrent assertions on the channel ports.
`timescale 1ns/10ps
module dct_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic byte_read,
  input wire logic byte_written,
  input wire logic burst_done,
  input wire logic xfer_req,
  input wire logic channel_busy_flag,
  input wire logic [23:0] dest_addr,
  input wire logic [15:0] block_byte_count,
  input wire logic [1:0] dest_step_mode
);
  logic run;
  logic rd_ap;
  logic ac_ap;
  logic ap;
  logic wr_only;
  assign ap = hsel && hready && htrans[1];
  assign wr_only = run && byte_written && !byte_read && !burst_done;
  // The run flag keeps count checks out of the wait for a trigger.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run <= 1'b0;
      rd_ap <= 1'b0;
      ac_ap <= 1'b0;
    end else begin
      rd_ap <= ap && !hwrite;
      ac_ap <= ap && hwrite && haddr[9:2] == dct_pkg::DCT_IDX_ADDRCTRL;
      if (xfer_req)
        run <= 1'b1;
      else if (!channel_busy_flag ||
               (byte_read && block_byte_count == 16'h0001))
        run <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!rd_ap |-> hrdata == 32'h0)
    else $error("read data outside a data phase");
  a_reset_vals: assert property (disable iff (1'b0) !rst_n |=>
    block_byte_count == 16'h0001 && !channel_busy_flag && !xfer_req
    && dest_addr == 24'h0 && dest_step_mode == 2'h0)
    else $error("wrong values after reset");
  a_step_lock: assert property (ac_ap && channel_busy_flag |=>
    $stable(dest_step_mode)) else $error("step mode changed while busy");
  a_count_dec: assert property (run && byte_read &&
    block_byte_count != 16'h0001 |=>
    block_byte_count == $past(block_byte_count) - 16'h0001)
    else $error("count did not step down");
  a_count_nz: assert property (run |-> block_byte_count != 16'h0)
    else $error("zero count inside a block");
  a_dest_inc: assert property (wr_only &&
    dest_step_mode == dct_pkg::DCT_DIR_INC |=>
    dest_addr == $past(dest_addr) + 24'h1) else $error("no increment");
  a_dest_dec: assert property (wr_only &&
    dest_step_mode == dct_pkg::DCT_DIR_DEC |=>
    dest_addr == $past(dest_addr) - 24'h1) else $error("no decrement");
  a_dest_fixed: assert property (wr_only && dest_step_mode == 2'h0 |=>
    $stable(dest_addr)) else $error("fixed address moved");
  a_xfer_busy: assert property (xfer_req |-> channel_busy_flag)
    else $error("block started while idle");
  c_xfer: cover property (xfer_req);
  c_lock: cover property (ac_ap && channel_busy_flag);
  c_end: cover property (run && byte_read && block_byte_count == 16'h1);
endmodule // dct_checker

bind dct_channel dct_checker chk (.clk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .byte_read, .byte_written, .burst_done,
  .xfer_req, .channel_busy_flag, .dest_addr, .block_byte_count,
  .dest_step_mode);

// *** verif/dct_periph.sv ***
// Request sources: event channels and peripherals facing the channel.
`timescale 1ns/10ps
module dct_periph (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [7:0] code,
  input wire logic flood,
  input wire logic xfer_req,
  output logic [2:0] ev_req,
  output logic crypto_req,
  output logic [4:0] adc0_req,
  output logic [1:0] dac0_req,
  output logic [4:0] adc1_req,
  output logic [1:0] dac1_req,
  output logic [3:0][5:0] port_timer0_req,
  output logic [3:0][3:0] port_timer1_req,
  output logic [3:0] port_spi_req,
  output logic [3:0][1:0] port_ser0_req,
  output logic [3:0][1:0] port_ser1_req
);
  logic [255:0] lvl;
  logic [255:0] line;
  // Servicing clears the flag, so the level falls when a block starts.
  always_ff @(posedge clk) begin
    if (!rst_n || xfer_req)
      lvl <= '0;
    else if (fire)
      lvl[code] <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  // Flooding raises every line, so only the select decides a start.
  assign line = lvl | {256{flood}};
  assign ev_req = line[3:1];
  assign crypto_req = line[4];
  assign adc0_req = line[20:16];
  assign dac0_req = line[22:21];
  assign adc1_req = line[36:32];
  assign dac1_req = line[38:37];
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      port_timer0_req[p] = line[64 + 32 * p +: 6];
      port_timer1_req[p] = line[70 + 32 * p +: 4];
      port_spi_req[p] = line[74 + 32 * p];
      port_ser0_req[p] = line[75 + 32 * p +: 2];
      port_ser1_req[p] = line[78 + 32 * p +: 2];
    end
  end
endmodule // dct_periph

// *** verif/dct_channel_tb.sv ***
// Self-checking bench for the channel with random transfers.
`timescale 1ns/10ps
module dct_channel_tb;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, seed, q[$];
  logic [1:0] htrans, dest_step_mode, dac0_req, dac1_req, st, rl;
  logic [2:0] hsize, ev_req;
  logic crypto_req, byte_read, byte_written, burst_done, xfer_error;
  logic xfer_req, channel_busy_flag, fire, flood, dp, ign;
  logic [4:0] adc0_req, adc1_req;
  logic [3:0][5:0] port_timer0_req;
  logic [3:0][3:0] port_timer1_req;
  logic [3:0] port_spi_req;
  logic [3:0][1:0] port_ser0_req, port_ser1_req;
  logic [23:0] dest_addr, d0, e;
  logic [15:0] block_byte_count, n;
  logic [7:0] code, c, p;
  logic [7:0] tab [11] = '{8'h03, 8'h04, 8'h14, 8'h16, 8'h23, 8'h26,
                           8'h05, 8'h09, 8'h0a, 8'h0c, 8'h0e};
  logic [7:0] absent [4] = '{8'h05, 8'h17, 8'h50, 8'h00};
  int n_mismatch, total_checks, pend_x, w;
  assign hready = hreadyout;
  dct_channel uut (.*);
  dct_periph per (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] nx();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // One single word transfer; a read notes its expected data first.
  task automatic bus(input logic wr, input logic [7:0] i, logic [31:0] d);
    @(posedge clk);
    {hsel, hwrite, htrans, hsize} <= {1'b1, wr, 2'h2, 3'h2};
    haddr <= {22'h0, i, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    dp <= !wr;
    if (!wr)
      q.push_back(d);
    do @(posedge clk); while (hready !== 1'b1);
    dp <= 1'b0;
  endtask
  task automatic pulse(input logic r, wb, b);
    {byte_read, byte_written, burst_done} <= {r, wb, b};
    @(posedge clk);
    {byte_read, byte_written, burst_done} <= 3'h0;
    @(posedge clk);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic waitx();
    w = 0;
    while (pend_x != 0 && w < 40) begin
      @(posedge clk);
      w++;
    end
    chk("xfer wait", pend_x, 0);
  endtask
  always @(posedge clk) begin
    if (dp)
      chk("hrdata", hrdata, q.pop_front());
    if (dp)
      chk("hresp", 32'(hresp), 32'h0);
    if (xfer_req === 1'b1 && !ign) begin
      chk("xfer_req", pend_x, 1);
      pend_x = 0;
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial begin
    {rst_n, hsel, hwrite, fire, flood, dp, ign, pend_x} = '0;
    {byte_read, byte_written, burst_done, xfer_error} = 4'h0;
    {haddr, hwdata, htrans, hsize, code} = '0;
    seed = 32'ha3b6;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("count", 32'(block_byte_count), 32'h1);
    bus(0, 8'h03, 32'h0);
    bus(0, 8'h04, 32'h1);
    bus(0, 8'h06, 32'h0);
    bus(0, 8'h07, 32'h0);
    foreach (absent[i]) begin
      bus(1, 8'h03, {24'h0, absent[i]});
      bus(1, 8'h00, 32'h1);
      flood <= 1'b1;
      repeat (10) @(posedge clk);
      flood <= 1'b0;
      chk("busy", 32'(channel_busy_flag), 32'h1);
      bus(1, 8'h00, 32'h0);
      settle();
      chk("busy", 32'(channel_busy_flag), 32'h0);
    end
    pend_x = 1;
    bus(1, 8'h00, 32'h5);
    waitx();
    pulse(1'b1, 1'b0, 1'b0);
    settle();
    chk("busy", 32'(channel_busy_flag), 32'h0);
    bus(0, 8'h10, 32'h2);
    bus(1, 8'h10, 32'h6);
    for (int i = 0; i < 11; i++) begin
      p = 8'(nx() % 4);
      c = tab[i] + (i > 5 ? 8'h40 + 8'h20 * p : 8'h0);
      st = 2'(i % 3);
      rl = 2'(i % 4);
      n = 16'(2 + nx() % 3);
      d0 = 24'(nx());
      e = rl != 2'h0 ? d0 : st == 2'h1 ? d0 + n : st == 2'h2 ? d0 - n : d0;
      bus(1, 8'h02, {28'h0, rl, st});
      bus(1, 8'h0c, {8'h0, d0});
      bus(1, 8'h04, 32'(n));
      bus(1, 8'h05, 32'h0);
      bus(1, 8'h03, {24'h0, c});
      bus(0, 8'h03, {24'h0, c});
      bus(1, 8'h00, 32'h1);
      bus(1, 8'h02, {28'h0, ~rl, ~st});
      #1;
      chk("step", 32'(dest_step_mode), 32'(st));
      pend_x = 1;
      fire <= 1'b1;
      code <= c;
      @(posedge clk);
      fire <= 1'b0;
      waitx();
      for (int k = 0; k < n; k++) begin
        pulse(1'b0, 1'b1, 1'b0);
        pulse(1'b1, 1'b0, k == n - 1);
        chk("count", 32'(block_byte_count), n - (k + 1) % n);
      end
      settle();
      chk("dest", 32'(dest_addr), 32'(e));
      chk("busy", 32'(channel_busy_flag), 32'h0);
      bus(1, 8'h10, 32'h6);
    end
    ign = 1'b1;
    bus(1, 8'h06, 32'h2);
    bus(1, 8'h04, 32'h2);
    bus(1, 8'h00, 32'h7);
    repeat (8) @(posedge clk);
    repeat (2) pulse(1'b1, 1'b0, 1'b0);
    bus(0, 8'h06, 32'h1);
    chk("busy", 32'(channel_busy_flag), 32'h1);
    bus(1, 8'h00, 32'h7);
    settle();
    repeat (2) pulse(1'b1, 1'b0, 1'b0);
    settle();
    chk("busy", 32'(channel_busy_flag), 32'h0);
    bus(0, 8'h00, 32'h0);
    bus(0, 8'h06, 32'h0);
    bus(1, 8'h04, 32'h0);
    bus(1, 8'h00, 32'h5);
    settle();
    chk("count", 32'(block_byte_count), 32'hffff);
    pulse(1'b1, 1'b0, 1'b0);
    chk("count", 32'(block_byte_count), 32'hfffe);
    bus(1, 8'h00, 32'h0);
    settle();
    chk("busy", 32'(channel_busy_flag), 32'h0);
    bus(1, 8'h10, 32'h6);
    bus(1, 8'h06, 32'h0);
    bus(1, 8'h04, 32'h1);
    bus(1, 8'h05, 32'h0);
    bus(1, 8'h00, 32'h7);
    settle();
    pulse(1'b1, 1'b0, 1'b0);
    settle();
    chk("busy", 32'(channel_busy_flag), 32'h1);
    xfer_error <= 1'b1;
    @(posedge clk);
    xfer_error <= 1'b0;
    settle();
    chk("busy", 32'(channel_busy_flag), 32'h0);
    bus(0, 8'h10, 32'h6);
    results();
  end
endmodule // dct_channel_tb
